// *** rtl/fts_sram_port.sv ***
`timescale 1ns/1ps
`include "fts_regs.svh"

// Function
// R01: Processor strobe low captures address and loads burst counter bits.
// R02: Processor strobe ignored while first chip enable is high.
// R03: Controller strobe low captures address and loads burst counter bits.
// R04: Both strobes low: only the processor strobe is acted upon.
// R05: Host drives byte write enable low with byte selects for byte writes.
// R06: Sleep high enters a retaining low-activity state, asynchronously.
// R07: Sleep held low or floating; floating reads as normal operation.
// R08: Input data lines are registered on the rising clock edge.
// R09: Read data is the location addressed at the preceding edge, unregistered.
// R10: Output enable low drives data and parity; high floats them, async.
// R11: Outputs float in write data phase, first cycle after deselect, deselected.
// R12: Parity lines act like data; each written only with its byte select.
// R13: Strap low selects linear order; high or floating selects interleaved.
// R14: System keeps the burst-order strap constant during operation.
// R15: Global write low writes all bytes regardless of byte enables.
// R16: Byte selects count only when byte write enable is asserted.
// R17: Chip enables sampled only when a new external address loads.
// R18: Burst advance low during a burst increments the burst address.
// R19: Counter wraps in four; interleaved XORs, linear adds, count modulo four.
module fts_sram_port (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire fts_pkg::fts_addr_s addr_i,
   input wire fts_pkg::fts_wr_s wr_i,
   input wire logic output_enable_n_i,
   input wire logic sleep_request_i,
   input wire logic sleep_request_oe_i,
   input wire logic mode_i,
   input wire logic mode_oe_i,
   input wire logic [`FTS_DATA_W-1:0] data_i,
   input wire logic [`FTS_BYTES-1:0] parity_lines_i,
   output logic [`FTS_DATA_W-1:0] data_o,
   output logic [`FTS_BYTES-1:0] parity_lines_o,
   output logic data_oe_o,
   output logic sleeping_o
);
   localparam int AW = `FTS_ADDR_W;
   // One word holds all four data lanes and, above them, their parity bits
   localparam int BW = `FTS_DATA_W + `FTS_BYTES;

   fts_pkg::fts_state_e state_r, state_nxt;
   logic [AW-1:0] addr_r, addr_nxt;
   logic first_r, first_nxt;
   logic [BW-1:0] mem_r [`FTS_DEPTH];
   logic [BW-1:0] mem_nxt [`FTS_DEPTH];
   logic [`FTS_DATA_W-1:0] din_r;
   logic [`FTS_BYTES-1:0] pin_r;
   logic [`FTS_DATA_W-1:0] rd_data;
   logic [`FTS_BYTES-1:0] rd_par;
   logic sleep;
   logic mode;
   logic proc_go;
   logic ctrl_go;
   logic load;
   logic selected;
   logic wr_any;
   logic [`FTS_BYTES-1:0] byte_we;
   logic step;
   fts_pkg::fts_burst_t burst;
   logic [AW-1:0] cur_addr;

   // Floating pins fall back to the internal pull resistors
   assign sleep = sleep_request_oe_i ? sleep_request_i
                                     : `FTS_SLEEP_FLOAT; // see R07
   assign mode = mode_oe_i ? mode_i : `FTS_MODE_FLOAT; // see R13

   // Byte enables of a write: global write overrides byte qualifiers
   function automatic logic [`FTS_BYTES-1:0] write_bytes(
      input fts_pkg::fts_wr_s w
   );
      if (!w.global_write_n) begin
         write_bytes = {`FTS_BYTES{1'b1}}; // see R15
      end else if (!w.byte_write_enable_n) begin
         write_bytes = ~w.byte_write_select_n; // see R16
      end else begin
         write_bytes = {`FTS_BYTES{1'b0}};
      end
   endfunction

   // Strobe decode with processor priority and first enable gating
   assign proc_go = !addr_i.proc_strobe_n
                    && !addr_i.ce_first_n; // see R02
   assign ctrl_go = !addr_i.ctrl_strobe_n
                    && addr_i.proc_strobe_n; // see R04
   assign load = (proc_go || ctrl_go) && !sleep;
   assign selected = !addr_i.ce_first_n && addr_i.ce_second
                     && !addr_i.ce_third_n; // see R17
   assign byte_we = write_bytes(wr_i);
   assign wr_any = |byte_we;
   assign step = !load && !sleep && !addr_i.burst_step_n
                 && (state_r != fts_pkg::FTS_DESEL); // see R18
   assign cur_addr = {addr_r[AW-1:`FTS_BURST_W], burst};

   fts_burst_counter u_burst (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .load_i(load && selected),
      .step_i(step),
      .mode_i(mode),
      .start_i(addr_i.addr[`FTS_BURST_W-1:0]),
      .burst_o(burst)
   );

   // Cycle state: address phase loads, later edges follow write inputs
   always_comb begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      first_nxt = 1'b0;
      if (sleep) begin
         state_nxt = state_r; // see R06
      end else if (load) begin
         if (selected) begin
            addr_nxt = addr_i.addr; // see R01 R03
            first_nxt = (state_r == fts_pkg::FTS_DESEL); // see R11
            // Processor strobe ignores write inputs in its first cycle
            if (ctrl_go && wr_any) begin
               state_nxt = fts_pkg::FTS_WRITE;
            end else begin
               state_nxt = fts_pkg::FTS_READ;
            end
         end else begin
            state_nxt = fts_pkg::FTS_DESEL; // see R17
         end
      end else if (state_r != fts_pkg::FTS_DESEL) begin
         state_nxt = wr_any ? fts_pkg::FTS_WRITE : fts_pkg::FTS_READ;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r <= fts_pkg::FTS_DESEL;
         addr_r <= '0;
         first_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         first_r <= first_nxt;
      end
   end

   // Input data register, captured every edge while awake
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         din_r <= '0;
         pin_r <= '0;
      end else if (!sleep) begin
         din_r <= data_i; // see R08
         pin_r <= parity_lines_i; // see R12
      end
   end

   // Array write: a write edge stores the bytes it enables
   always_comb begin
      mem_nxt = mem_r;
      // A load edge never writes: the old burst address would be hit
      if (!sleep && state_r != fts_pkg::FTS_DESEL && wr_any
          && !load) begin
         for (int b = 0; b < `FTS_BYTES; b++) begin
            if (byte_we[b]) begin
               mem_nxt[cur_addr][`FTS_DATA_W+b] =
                  parity_lines_i[b]; // see R12
               mem_nxt[cur_addr][b*`FTS_BYTE_W +: `FTS_BYTE_W] =
                  data_i[b*`FTS_BYTE_W +: `FTS_BYTE_W];
            end
         end
      end
   end

   // Storage lives in plain flops, cleared only by reset
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < `FTS_DEPTH; i++) begin
            mem_r[i] <= '0;
         end
      end else begin
         mem_r <= mem_nxt; // see R06
      end
   end

   // Flow-through read path straight from the array
   always_comb begin
      rd_data = mem_r[cur_addr][`FTS_DATA_W-1:0]; // see R09
      rd_par = mem_r[cur_addr][BW-1:`FTS_DATA_W]; // see R12
   end

   // Output drivers gated asynchronously by output enable
   assign data_oe_o = !output_enable_n_i && !sleep // see R10
                      && state_r == fts_pkg::FTS_READ
                      && !first_r; // see R11
   assign data_o = rd_data;
   assign parity_lines_o = rd_par;
   assign sleeping_o = sleep; // see R06
endmodule

// *** rtl/fts_regs.svh ***
`ifndef FTS_REGS_SVH
`define FTS_REGS_SVH

// Geometry of the modelled array, kept small so flip-flop storage is sane
`define FTS_ADDR_W 6
`define FTS_DEPTH 64
`define FTS_BYTES 4
`define FTS_BYTE_W 8
`define FTS_DATA_W 32
// Burst counter field in the address
`define FTS_BURST_LSB 0
`define FTS_BURST_W 2
// Strap and sleep defaults seen when the pins float
`define FTS_MODE_FLOAT 1'b1
`define FTS_SLEEP_FLOAT 1'b0
// Burst order encodings of the strap level
`define FTS_MODE_LINEAR 1'b0
`define FTS_MODE_INTERLEAVED 1'b1

`endif

// *** rtl/fts_pkg.sv ***
package fts_pkg;
   // Bus cycle state of the port
   typedef enum logic [1:0] {
      FTS_DESEL,
      FTS_READ,
      FTS_WRITE
   } fts_state_e;

   // Address phase request as sampled on the pins
   typedef struct packed {
      logic [5:0] addr;
      logic proc_strobe_n;
      logic ctrl_strobe_n;
      logic burst_step_n;
      logic ce_first_n;
      logic ce_second;
      logic ce_third_n;
   } fts_addr_s;

   // Write control as sampled on the pins
   typedef struct packed {
      logic global_write_n;
      logic byte_write_enable_n;
      logic [3:0] byte_write_select_n;
   } fts_wr_s;

   typedef logic [1:0] fts_burst_t;
endpackage

// *** rtl/fts_burst_counter.sv ***
`timescale 1ns/1ps
`include "fts_regs.svh"

// Two-bit wraparound burst counter with strap-selected order
module fts_burst_counter (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic load_i,
   input wire logic step_i,
   input wire logic mode_i,
   input wire fts_pkg::fts_burst_t start_i,
   output fts_pkg::fts_burst_t burst_o
);
   fts_pkg::fts_burst_t start_r, start_nxt;
   fts_pkg::fts_burst_t count_r, count_nxt;

   // Next burst address from start bits and count
   function automatic fts_pkg::fts_burst_t next_addr(
      input fts_pkg::fts_burst_t s,
      input fts_pkg::fts_burst_t c,
      input logic m
   );
      if (m == `FTS_MODE_INTERLEAVED) begin
         next_addr = s ^ c; // see R19
      end else begin
         next_addr = fts_pkg::fts_burst_t'(s + c); // see R19
      end
   endfunction

   // Load restarts the count, a step advances it
   always_comb begin
      start_nxt = start_r;
      count_nxt = count_r;
      if (load_i) begin
         start_nxt = start_i; // see R01 R03
         count_nxt = 2'h0;
      end else if (step_i) begin
         count_nxt = fts_pkg::fts_burst_t'(count_r + 2'h1); // see R18
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         start_r <= 2'h0;
         count_r <= 2'h0;
      end else begin
         start_r <= start_nxt;
         count_r <= count_nxt;
      end
   end

   assign burst_o = next_addr(start_r, count_r, mode_i); // see R13
endmodule

// *** dv/fts_sram_port_props.sv ***
`timescale 1ns/1ps
// Port-level checks of the flow-through port
module fts_sram_port_props (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire fts_pkg::fts_addr_s addr_i,
   input wire fts_pkg::fts_wr_s wr_i,
   input wire logic output_enable_n_i,
   input wire logic sleep_request_i,
   input wire logic sleep_request_oe_i,
   input wire logic [31:0] data_o,
   input wire logic data_oe_o,
   input wire logic sleeping_o
);
   logic slp, ld, sel, nw;
   // Effective sleep, address load edge, full select, no write
   assign slp = sleep_request_oe_i & sleep_request_i;
   assign ld = !slp && (!addr_i.proc_strobe_n ? !addr_i.ce_first_n
      : !addr_i.ctrl_strobe_n);
   assign sel = !addr_i.ce_first_n & addr_i.ce_second & !addr_i.ce_third_n;
   assign nw = wr_i.global_write_n & wr_i.byte_write_enable_n;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   property p_oe; output_enable_n_i |-> !data_oe_o; endproperty
   a_oe: assert property (p_oe) else $error("oe high");
   property p_desel; ld && !sel |=> !data_oe_o; endproperty
   a_desel: assert property (p_desel) else $error("desel");
   property p_first; ld && !sel ##1 ld && sel |=> !data_oe_o; endproperty
   a_first: assert property (p_first) else $error("first");
   property p_slp; sleeping_o == slp; endproperty
   a_slp: assert property (p_slp) else $error("sleep flag");
   property p_frz; slp |=> $stable(data_o); endproperty
   a_frz: assert property (p_frz) else $error("sleep move");
   property p_keep; !ld && addr_i.burst_step_n && nw |=> $stable(data_o);
   endproperty
   a_keep: assert property (p_keep) else $error("moved");
   property p_hold; data_oe_o && !ld && nw |=> data_oe_o | output_enable_n_i
      | slp;
   endproperty
   a_hold: assert property (p_hold) else $error("dropped");
   property p_wr; !ld && !slp && !wr_i.global_write_n |=> !data_oe_o;
   endproperty
   a_wr: assert property (p_wr) else $error("write driven");
   c_rd: cover property (ld && sel && nw);
   c_wr: cover property (!ld && !wr_i.global_write_n);
   c_slp: cover property (slp ##1 !slp);
endmodule
bind fts_sram_port fts_sram_port_props i_fts_sram_port_props (
   .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i),
   .output_enable_n_i(output_enable_n_i), .sleep_request_i(sleep_request_i),
   .sleep_request_oe_i(sleep_request_oe_i), .data_o(data_o),
   .data_oe_o(data_oe_o), .sleeping_o(sleeping_o));

// *** dv/fts_host_model.sv ***
`timescale 1ns/1ps
// Host bus master: pins change just after a rising edge
module fts_host_model (
   input wire logic clk_i,
   output fts_pkg::fts_addr_s addr_o,
   output fts_pkg::fts_wr_s wr_o,
   output logic [35:0] dq_o,
   output logic drive_o,
   output logic [4:0] pins_o
);
   // Idle bus, sleep and strap floating
   initial begin
      addr_o = 12'h03a;
      wr_o = 6'h3f;
      dq_o = 36'h0;
      drive_o = 1'b0;
      pins_o = 5'b00000;
   end
   // One bus cycle, held until the next edge samples it
   task automatic cyc(input fts_pkg::fts_addr_s a, input fts_pkg::fts_wr_s w,
      input logic [35:0] d, input logic drv);
      @(posedge clk_i);
      addr_o <= a;
      wr_o <= w;
      dq_o <= d;
      drive_o <= drv;
   endtask
   // Oe_n, sleep, sleep driven, strap, strap driven; between bursts only
   task automatic set_pins(input logic [4:0] v);
      @(posedge clk_i);
      pins_o <= v;
   endtask
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
// Self-checking bench for the flow-through port
module testbench;
   localparam fts_pkg::fts_addr_s IDLE = 12'h03a;
   localparam fts_pkg::fts_wr_s WN = 6'h3f;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   int mismatches = 0;
   int compares = 0;
   logic [35:0] mem [64];
   fts_pkg::fts_addr_s ha;
   fts_pkg::fts_wr_s hw;
   logic [35:0] hd, dq, dout;
   logic [4:0] pn;
   logic drv, oe, slp;
   // Data pins: host, else port, else inverse of last host value
   assign dq = drv ? hd : oe ? dout : ~hd;
   fts_host_model h (.clk_i(clk_i), .addr_o(ha), .wr_o(hw), .dq_o(hd),
      .drive_o(drv), .pins_o(pn));
   fts_sram_port i_fts_sram_port (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(ha),
      .wr_i(hw), .output_enable_n_i(pn[4]), .sleep_request_i(pn[3]),
      .sleep_request_oe_i(pn[2]), .mode_i(pn[1]), .mode_oe_i(pn[0]),
      .data_i(dq[31:0]), .parity_lines_i(dq[35:32]), .data_o(dout[31:0]),
      .parity_lines_o(dout[35:32]), .data_oe_o(oe), .sleeping_o(slp));
   initial forever #2.5 clk_i = ~clk_i;
   function automatic fts_pkg::fts_addr_s ad(logic [5:0] a, logic p,
      logic c, logic s, logic e);
      return {a, p, c, s, e, 2'b10};
   endfunction
   // Controller load, write edge, release; model the stored lanes
   task automatic wr_word(logic [5:0] a, fts_pkg::fts_wr_s w,
      logic [35:0] d, logic live);
      h.cyc(ad(a, 1, 0, 1, 0), w, d, 1'b1);
      h.cyc(ad(a, 1, 1, 1, 0), w, d, 1'b1);
      h.cyc(IDLE, WN, d, 1'b0);
      for (int b = 0; b < 4; b++)
         if (live && (!w.global_write_n || !(w.byte_write_enable_n
            | w.byte_write_select_n[b]))) begin
            mem[a][8*b +: 8] = d[8*b +: 8];
            mem[a][32+b] = d[32+b];
         end
   endtask
   // Deselect, processor load, then step through the group
   task automatic rd_burst(logic [5:0] a, logic lin);
      logic [5:0] x;
      h.cyc(ad(a, 1, 0, 1, 1), WN, 36'h0, 1'b0);
      h.cyc(ad(a, 0, 1, 1, 0), WN, 36'h0, 1'b0);
      for (int k = 0; k < 4; k++) begin
         h.cyc(ad(a, 1, 1, k == 3, 0), WN, 36'h0, 1'b0);
         #1;
         x = {a[5:2], lin ? a[1:0] + k[1:0] : a[1:0] ^ k[1:0]};
         `CHK(dout, mem[x])
         `CHK(oe, k != 0)
      end
   endtask
   // Global writes, then bursts for each strap setting
   task automatic t_burst();
      for (int i = 0; i < 8; i++)
         wr_word(6'(i), 6'h1f, {4'(i), 32'(32'h11111111 * (i + 1))}, 1'b1);
      h.set_pins(5'b00001);
      rd_burst(6'h06, 1'b1);
      h.set_pins(5'b00011);
      rd_burst(6'h05, 1'b0);
      h.set_pins(5'b00000);
      rd_burst(6'h03, 1'b0);
      $display("burst test done");
   endtask
   // Byte lanes with and without the byte enable
   task automatic t_byte();
      wr_word(6'h09, 6'h2a, 36'ha_5a5a_5a5a, 1'b1);
      wr_word(6'h09, 6'h30, 36'h0, 1'b1);
      rd_burst(6'h09, 1'b0);
      $display("byte test done");
   endtask
   // Refused strobes, then output enable
   task automatic t_refuse();
      h.cyc(ad(6'h04, 0, 1, 1, 0), WN, 36'h0, 1'b0);
      h.cyc(IDLE, WN, 36'h0, 1'b0);
      h.cyc(ad(6'h0c, 0, 0, 1, 1), WN, 36'h0, 1'b0);
      h.cyc(IDLE, WN, 36'h0, 1'b0);
      #1;
      `CHK(dout, mem[4])
      `CHK(oe, 1'b1)
      h.set_pins(5'b10000);
      #1;
      `CHK(oe, 1'b0)
      h.set_pins(5'b00000);
      #1;
      `CHK(oe, 1'b1)
      $display("refuse test done");
   endtask
   // Write attempt in sleep is lost; floating sleep is normal
   task automatic t_sleep();
      h.set_pins(5'b01100);
      #1;
      `CHK(slp, 1'b1)
      wr_word(6'h04, 6'h1f, 36'hf_0000_0000, 1'b0);
      h.set_pins(5'b01000);
      #1;
      `CHK(slp, 1'b0)
      rd_burst(6'h04, 1'b0);
      $display("sleep test done");
   endtask
   task automatic stop_test();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      foreach (mem[i]) mem[i] = 36'h0;
      repeat (4) @(posedge clk_i);
      nrst_i <= 1'b1;
      t_burst();
      t_byte();
      t_refuse();
      t_sleep();
      stop_test();
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      $display("timeout");
      stop_test();
   end
endmodule
